// File: fifo_power_defs.svh
`ifndef FIFO_POWER_DEFS_SVH
`define FIFO_POWER_DEFS_SVH

// ============================================================
// Register map, byte addresses on the register bus.
`define ADR_W              8
`define ADR_ENDIAN_TEST    8'h64
`define ADR_RX_FIFO_INFO   8'h7c
`define ADR_TX_FIFO_INFO   8'h80
`define ADR_POWER_CTRL     8'h84
`define DATA_W             32
`define SEL_W              4

// ============================================================
// Field positions.
`define USED_WORDS_MSB     23
`define USED_WORDS_LSB     16
`define BYTES_MSB          15
`define BYTES_LSB          0
`define POWER_STATE_MSB    13
`define POWER_STATE_LSB    12
`define PHY_RESET_BIT      10
`define WAKE_ON_LAN_BIT    9
`define ENERGY_DETECT_BIT  8
`define DRV_TYPE_BIT       6
`define PULSE_MODE_BIT     3
`define POLARITY_BIT       2
`define OUT_EN_BIT         1
`define READY_BIT          0
`define LANE1_SEL          1
`define LANE0_SEL          0

// ============================================================
// Reset values.
`define STS_USED_RST       8'h00
`define RX_USED_RST        16'h0000
`define TX_FREE_RST        16'h1200

// ============================================================
// Timing and counter widths.
`define CLK_PERIOD_NS      40
`define PHY_RESET_MIN_NS   100000
`define WAKE_PULSE_NS      50000000
`define SETTLE_CYCLES      16
`define PHY_CNT_W          12
`define PULSE_CNT_W        21
`define SETTLE_CNT_W       5

`endif

// File: fifo_power_pkg.sv
`include "fifo_power_defs.svh"

package fifo_power_pkg;

  // ============================================================
  // Power states and counter types.
  typedef enum logic [1:0]
  {
    FULL_POWER                = 2'b00,
    WAKE_FRAME_SLEEP_STATE    = 2'b01,
    ENERGY_DETECT_SLEEP_STATE = 2'b10,
    RESERVED_POWER_STATE      = 2'b11
  } power_state_t;

  typedef logic [`PHY_CNT_W-1:0]    phy_cnt_t;
  typedef logic [`PULSE_CNT_W-1:0]  pulse_cnt_t;
  typedef logic [`SETTLE_CNT_W-1:0] settle_cnt_t;

  // ============================================================
  // Register block state.
  typedef struct packed {
    power_state_t       pm;
    logic               phy_reset_request;
    phy_cnt_t           phy_cnt;
    logic               wake_on_lan_enable;
    logic               energy_detect_enable;
    logic               drv_type;
    logic               pulse_mode;
    logic               polarity;
    logic               out_en;
    logic               read_seen;
    logic               ready;
    settle_cnt_t        settle_cnt;
    logic [7:0]         rx_sts;
    logic [15:0]        rx_data;
    logic [7:0]         tx_sts;
    logic [15:0]        tx_free;
    logic               wake_int;
    logic               ack;
    logic [`DATA_W-1:0] rdata;
  } regs_state_t;

  // Wake output driver state.
  typedef struct packed {
    logic       wol_hit;
    logic       ed_hit;
    pulse_cnt_t pulse_cnt;
    logic       pin;
    logic       pin_oe;
  } wake_state_t;

  // Converts a time to clock cycles, never less than one cycle.
  function automatic int ns_to_cycles(input int ns, input bit round_up);
    int c;
    c = round_up ? (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS : ns / `CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

endpackage

// File: wake_ctl_if.sv
`timescale 1ns/1ps

// ============================================================
// Configuration and events toward the wake output driver.
interface wake_ctl_if;
  logic wol_event;
  logic ed_event;
  logic wake_on_lan_enable;
  logic energy_detect_enable;
  logic out_en;
  logic pulse_mode;
  logic drv_type;
  logic polarity;
  logic pin;
  logic pin_oe;

  modport ctrl
  (
    output wol_event, ed_event, wake_on_lan_enable, energy_detect_enable,
    output out_en, pulse_mode, drv_type, polarity,
    input  pin, pin_oe
  );

  modport drv
  (
    input  wol_event, ed_event, wake_on_lan_enable, energy_detect_enable,
    input  out_en, pulse_mode, drv_type, polarity,
    output pin, pin_oe
  );
endinterface

// File: wake_output_driver.sv
`timescale 1ns/1ps
`include "fifo_power_defs.svh"

module wake_output_driver #(
  parameter int PULSE_CYCLES = fifo_power_pkg::ns_to_cycles(`WAKE_PULSE_NS, 1'b0)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  wake_ctl_if.drv  ctl
);

  fifo_power_pkg::wake_state_t s_q;
  fifo_power_pkg::wake_state_t s_d;
  logic                        wol_now;
  logic                        ed_now;
  logic                        active;

  // ============================================================
  // Next state: latch causes, run the pulse timer, shape the pin.
  always_comb
  begin
    s_d     = s_q;
    wol_now = ctl.wol_event & ctl.wake_on_lan_enable;
    ed_now  = ctl.ed_event & ctl.energy_detect_enable;
    // A latched cause only falls when its enable is cleared.
    s_d.wol_hit = ctl.wake_on_lan_enable & (s_q.wol_hit | wol_now);
    s_d.ed_hit  = ctl.energy_detect_enable & (s_q.ed_hit | ed_now);
    if (wol_now | ed_now)
    begin
      s_d.pulse_cnt = fifo_power_pkg::pulse_cnt_t'(PULSE_CYCLES);
    end
    else if (!(ctl.wake_on_lan_enable | ctl.energy_detect_enable))
    begin
      s_d.pulse_cnt = '0;
    end
    else if (s_q.pulse_cnt != '0)
    begin
      s_d.pulse_cnt = s_q.pulse_cnt - 1'b1;
    end
    // Pulsed or static indication, gated only on the external pin.
    active = ctl.out_en & (ctl.pulse_mode ? (s_q.pulse_cnt != '0) : (s_q.wol_hit | s_q.ed_hit));
    if (!ctl.drv_type)
    begin
      // Open drain ignores polarity and only pulls low.
      s_d.pin    = 1'b0;
      s_d.pin_oe = active;
    end
    else
    begin
      // Push-pull always drives, level set by polarity.
      s_d.pin_oe = 1'b1;
      s_d.pin    = ctl.polarity ? active : ~active;
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ctl.pin    = s_q.pin;
  assign ctl.pin_oe = s_q.pin_oe;

  // ============================================================
  // Checks.
  open_drain_low_a: assert property (
    @(posedge clk_i) disable iff (rst_i) !ctl.drv_type |=> !ctl.pin)
    else $error("Open-drain wake pin drove high.");

  push_pull_drive_a: assert property (
    @(posedge clk_i) disable iff (rst_i) ctl.drv_type |=> ctl.pin_oe)
    else $error("Push-pull wake pin not driven.");

  output_gate_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ctl.out_en && ctl.drv_type |=> ctl.pin == !$past(ctl.polarity))
    else $error("Disabled wake pin was asserted.");

  pulse_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wol_now | ed_now) |=> s_q.pulse_cnt == fifo_power_pkg::pulse_cnt_t'(PULSE_CYCLES))
    else $error("Wake pulse timer not loaded.");

  static_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wol_now ##1 ctl.wake_on_lan_enable [*2] |-> s_q.wol_hit)
    else $error("Static wake cause was lost.");

endmodule

// File: host_fifo_level_power_regs.sv
`timescale 1ns/1ps
`include "fifo_power_defs.svh"

module host_fifo_level_power_regs #(
  parameter int WAKE_PULSE_CYCLES = fifo_power_pkg::ns_to_cycles(`WAKE_PULSE_NS, 1'b0)
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [`ADR_W-1:0]  adr_i,
  input  wire logic [`DATA_W-1:0] dat_i,
  output logic      [`DATA_W-1:0] dat_o,
  input  wire logic               we_i,
  input  wire logic [`SEL_W-1:0]  sel_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  output logic                    ack_o,
  input  wire logic [7:0]         rx_status_words_used_i,
  input  wire logic [15:0]        rx_data_bytes_used_i,
  input  wire logic [7:0]         tx_status_words_used_i,
  input  wire logic [15:0]        tx_data_bytes_free_i,
  input  wire logic               wol_event_i,
  input  wire logic               energy_event_i,
  output logic      [1:0]         power_state_select_o,
  output logic                    device_ready_o,
  output logic                    phy_reset_request_o,
  output logic                    wake_interrupt_o,
  output logic                    wake_request_output_o,
  output logic                    wake_request_output_oe_o
);

  // ============================================================
  // Timing constants.
  localparam int PHY_RESET_CYCLES = fifo_power_pkg::ns_to_cycles(`PHY_RESET_MIN_NS, 1'b1);
  localparam fifo_power_pkg::phy_cnt_t PHY_LOAD =
    fifo_power_pkg::phy_cnt_t'(PHY_RESET_CYCLES - 1);
  localparam fifo_power_pkg::settle_cnt_t SETTLE_LOAD =
    fifo_power_pkg::settle_cnt_t'(`SETTLE_CYCLES);

  fifo_power_pkg::regs_state_t  s_q;
  fifo_power_pkg::regs_state_t  s_d;
  fifo_power_pkg::power_state_t new_mode;
  logic                         req;
  logic                         take;
  logic                         wr_commit;
  logic                         rd_commit;

  wake_ctl_if wake_ctl ();

  // ============================================================
  // Address decode and read mux.

  // Word-aligned match; the low two address bits are ignored, sel_i selects the byte lanes.
  function automatic logic addr_hit(input logic [`ADR_W-1:0] a, input logic [`ADR_W-1:0] off);
    return a[`ADR_W-1:2] == off[`ADR_W-1:2];
  endfunction

  function automatic logic [`DATA_W-1:0] read_word(input logic [`ADR_W-1:0]         a,
                                                   input fifo_power_pkg::regs_state_t s);
    logic [`DATA_W-1:0] w;
    w = '0; // Reserved bits and unmapped words read zero.
    if (addr_hit(a, `ADR_RX_FIFO_INFO))
    begin
      w[`USED_WORDS_MSB:`USED_WORDS_LSB] = s.rx_sts;
      w[`BYTES_MSB:`BYTES_LSB]           = s.rx_data;
    end
    else if (addr_hit(a, `ADR_TX_FIFO_INFO))
    begin
      w[`USED_WORDS_MSB:`USED_WORDS_LSB] = s.tx_sts;
      w[`BYTES_MSB:`BYTES_LSB]           = s.tx_free;
    end
    else if (addr_hit(a, `ADR_POWER_CTRL))
    begin
      // Readable in every power state, with no ready or mode check.
      w[`POWER_STATE_MSB:`POWER_STATE_LSB] = s.pm;
      w[`PHY_RESET_BIT]            = s.phy_reset_request;
      w[`WAKE_ON_LAN_BIT]          = s.wake_on_lan_enable;
      w[`ENERGY_DETECT_BIT]        = s.energy_detect_enable;
      w[`DRV_TYPE_BIT]             = s.drv_type;
      w[`PULSE_MODE_BIT]           = s.pulse_mode;
      w[`POLARITY_BIT]             = s.polarity;
      w[`OUT_EN_BIT]               = s.out_en;
      w[`READY_BIT]                = s.ready;
    end
    return w;
  endfunction

  // ============================================================
  // Bus handshake: ack follows one cycle after the request and falls
  // in the next cycle; writes land on the edge where ack is seen.
  assign req       = cyc_i & stb_i;
  assign take      = req & ~s_q.ack;
  assign wr_commit = req & s_q.ack & we_i;
  assign rd_commit = req & s_q.ack & ~we_i;
  assign new_mode  = fifo_power_pkg::power_state_t'(dat_i[`POWER_STATE_MSB:`POWER_STATE_LSB]);

  // ============================================================
  // Next-state logic for the whole register block.
  always_comb
  begin
    s_d = s_q;

    // Level inputs come from same-clock FIFO logic; one stage gives a
    // stable copy for the read path and a defined reset value.
    s_d.rx_sts  = rx_status_words_used_i;
    s_d.rx_data = rx_data_bytes_used_i;
    s_d.tx_sts  = tx_status_words_used_i;
    s_d.tx_free = tx_data_bytes_free_i;

    // The interrupt ignores the pin enable on purpose.
    s_d.wake_int = (wol_event_i & s_q.wake_on_lan_enable) |
                   (energy_event_i & s_q.energy_detect_enable);

    s_d.ack = take;
    if (take)
    begin
      s_d.rdata = read_word(adr_i, s_q);
    end

    // PHY reset self-times and self-clears.
    if (s_q.phy_reset_request)
    begin
      if (s_q.phy_cnt == '0)
      begin
        s_d.phy_reset_request = 1'b0;
      end
      else
      begin
        s_d.phy_cnt = s_q.phy_cnt - 1'b1;
      end
    end

    // Ready rises only after the settle time in full power.
    if (s_q.pm == fifo_power_pkg::FULL_POWER && !s_q.ready)
    begin
      if (s_q.settle_cnt == '0)
      begin
        s_d.ready = 1'b1;
      end
      else
      begin
        s_d.settle_cnt = s_q.settle_cnt - 1'b1;
      end
    end

    // Any completed read arms writes.
    if (rd_commit)
    begin
      s_d.read_seen = 1'b1;
    end

    if (wr_commit)
    begin
      if (addr_hit(adr_i, `ADR_ENDIAN_TEST))
      begin
        // Data is ignored; only the access wakes the device.
        if (s_q.pm != fifo_power_pkg::FULL_POWER)
        begin
          s_d.pm         = fifo_power_pkg::FULL_POWER;
          s_d.ready      = 1'b0;
          s_d.settle_cnt = SETTLE_LOAD;
          s_d.read_seen  = 1'b0;
        end
      end
      else if (addr_hit(adr_i, `ADR_POWER_CTRL) && s_q.read_seen)
      begin
        if (sel_i[`LANE1_SEL])
        begin
          // The reserved code and a plain full-power write leave the power state unchanged.
          if (new_mode != fifo_power_pkg::RESERVED_POWER_STATE &&
              new_mode != fifo_power_pkg::FULL_POWER)
          begin
            s_d.pm    = new_mode;
            s_d.ready = 1'b0;
          end
          s_d.wake_on_lan_enable   = dat_i[`WAKE_ON_LAN_BIT];
          s_d.energy_detect_enable = dat_i[`ENERGY_DETECT_BIT];
          // A running PHY reset cannot be restarted or cut short.
          if (!s_q.phy_reset_request && dat_i[`PHY_RESET_BIT])
          begin
            s_d.phy_reset_request = 1'b1;
            s_d.phy_cnt = PHY_LOAD;
          end
        end
        if (sel_i[`LANE0_SEL])
        begin
          s_d.drv_type   = dat_i[`DRV_TYPE_BIT];
          s_d.pulse_mode = dat_i[`PULSE_MODE_BIT];
          s_d.polarity   = dat_i[`POLARITY_BIT];
          s_d.out_en     = dat_i[`OUT_EN_BIT];
        end
      end
    end
  end

  // ============================================================
  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q            <= '0;
      s_q.tx_free    <= `TX_FREE_RST;
      s_q.rx_sts     <= `STS_USED_RST;
      s_q.tx_sts     <= `STS_USED_RST;
      s_q.rx_data    <= `RX_USED_RST;
      s_q.settle_cnt <= SETTLE_LOAD;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Wake output driver.
  assign wake_ctl.wol_event  = wol_event_i;
  assign wake_ctl.ed_event   = energy_event_i;
  assign wake_ctl.wake_on_lan_enable   = s_q.wake_on_lan_enable;
  assign wake_ctl.energy_detect_enable = s_q.energy_detect_enable;
  assign wake_ctl.out_en     = s_q.out_en;
  assign wake_ctl.pulse_mode = s_q.pulse_mode;
  assign wake_ctl.drv_type   = s_q.drv_type;
  assign wake_ctl.polarity   = s_q.polarity;

  wake_output_driver #(
    .PULSE_CYCLES (WAKE_PULSE_CYCLES)
  ) u_wake (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl   (wake_ctl.drv)
  );

  // Outputs, all taken from flip-flops.
  assign dat_o                    = s_q.rdata;
  assign ack_o                    = s_q.ack;
  assign power_state_select_o     = s_q.pm;
  assign device_ready_o           = s_q.ready;
  assign phy_reset_request_o      = s_q.phy_reset_request;
  assign wake_interrupt_o         = s_q.wake_int;
  assign wake_request_output_o    = wake_ctl.pin;
  assign wake_request_output_oe_o = wake_ctl.pin_oe;

  // ============================================================
  // Checks and the helper logic that only they read.
  int phy_high_cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phy_high_cnt <= 0;
    end
    else
    begin
      phy_high_cnt <= phy_reset_request_o ? phy_high_cnt + 1 : 0;
    end
  end

  rx_words_report_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take && !we_i && addr_hit(adr_i, `ADR_RX_FIFO_INFO)
    |=> dat_o[`USED_WORDS_MSB:`USED_WORDS_LSB] == $past(rx_status_words_used_i, 2))
    else $error("Receive status word count misreported.");

  rx_bytes_report_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take && !we_i && addr_hit(adr_i, `ADR_RX_FIFO_INFO)
    |=> dat_o[`BYTES_MSB:`BYTES_LSB] == $past(rx_data_bytes_used_i, 2))
    else $error("Receive data byte count misreported.");

  tx_words_report_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take && !we_i && addr_hit(adr_i, `ADR_TX_FIFO_INFO)
    |=> dat_o[`USED_WORDS_MSB:`USED_WORDS_LSB] == $past(tx_status_words_used_i, 2))
    else $error("Transmit status word count misreported.");

  tx_free_reset_a: assert property (
    @(posedge clk_i) $past(rst_i) && !rst_i |-> s_q.tx_free == `TX_FREE_RST)
    else $error("Transmit free count has wrong reset value.");

  reserved_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[`DATA_W-1:`USED_WORDS_MSB+1] == '0)
    else $error("Reserved bits read non-zero.");

  phy_hold_time_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(phy_reset_request_o) |-> phy_high_cnt == PHY_RESET_CYCLES)
    else $error("PHY reset held for the wrong time.");

  phy_write_ignored_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    phy_reset_request_o && $past(phy_reset_request_o)
    |-> s_q.phy_cnt == $past(s_q.phy_cnt) - 1'b1)
    else $error("PHY reset timer disturbed while running.");

  endian_wake_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_commit && addr_hit(adr_i, `ADR_ENDIAN_TEST) && s_q.pm != fifo_power_pkg::FULL_POWER
    |=> power_state_select_o == fifo_power_pkg::FULL_POWER && !device_ready_o
        ##[1:32] device_ready_o)
    else $error("Endian test write did not wake the device.");

  reserved_mode_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    power_state_select_o != fifo_power_pkg::RESERVED_POWER_STATE)
    else $error("Reserved power state entered.");

  ready_in_sleep_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    power_state_select_o != fifo_power_pkg::FULL_POWER |-> !device_ready_o)
    else $error("Ready shown in a reduced-power state.");

  write_before_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_commit && addr_hit(adr_i, `ADR_POWER_CTRL) && !s_q.read_seen
    |=> $stable(s_q.wake_on_lan_enable) && $stable(s_q.out_en) && $stable(s_q.drv_type))
    else $error("Write took effect before the first read.");

  wake_interrupt_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wol_event_i && s_q.wake_on_lan_enable) ||
    (energy_event_i && s_q.energy_detect_enable) |=> wake_interrupt_o)
    else $error("Enabled wake event gave no interrupt.");

  ack_single_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Bus ack held for more than one cycle.");

endmodule

// File: bus_host_model.sv
`timescale 1ns/1ps
`include "fifo_power_defs.svh"

// ============================================================
// Host processor model: classic Wishbone single cycles.
module bus_host_model (
  input  wire logic               clk_i,
  input  wire logic               ack_i,
  input  wire logic [`DATA_W-1:0] dat_i,
  output logic      [`ADR_W-1:0]  adr_o,
  output logic      [`DATA_W-1:0] dat_o,
  output logic      [`SEL_W-1:0]  sel_o,
  output logic                    we_o,
  output logic                    cyc_o,
  output logic                    stb_o,
  output logic                    stuck_o
);
  // Lines start idle so the slave never sees an unknown request.
  initial
  begin
    {adr_o, dat_o, sel_o, we_o, cyc_o, stb_o, stuck_o} = '0;
  end

  // One request held until ack is sampled; the bench only writes
  // the endian test register while not ready.
  task automatic xfer(input logic w, input logic [`ADR_W-1:0] a,
                      input logic [`DATA_W-1:0] d, output logic [`DATA_W-1:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o, sel_o} <= {2'b11, w, a, d, 4'hf};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!ack_i && n < 50);
    q = dat_i;
    if (!ack_i)
      stuck_o <= 1'b1;
    // On release cyc and stb drop, address and data are inverted so stale values never look driven.
    {cyc_o, stb_o} <= 2'b00;
    dat_o <= ~dat_o;
    adr_o <= ~adr_o;
  endtask
endmodule

// File: host_fifo_level_power_regs_test.sv
`timescale 1ns/1ps
`include "fifo_power_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %h got %h", nm, e, g); error_cnt++; end end

module host_fifo_level_power_regs_test;
  localparam int PW  = 20;
  localparam int LIM = 60;
  localparam logic [7:0] PC = `ADR_POWER_CTRL;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o, r;
  logic [3:0]  sel_i;
  logic        we_i, cyc_i, stb_i, ack_o, stuck, pp, pb;
  logic [7:0]  rx_status_words_used_i = 8'h00, tx_status_words_used_i = 8'h00;
  logic [15:0] rx_data_bytes_used_i = 16'h0000, tx_data_bytes_free_i = 16'h1200;
  logic        wol_event_i = 1'b0, energy_event_i = 1'b0;
  logic [1:0]  power_state_select_o;
  logic        device_ready_o, phy_reset_request_o, wake_interrupt_o;
  logic        wake_request_output_o, wake_request_output_oe_o;
  int          error_cnt = 0, checks_done = 0, seed = 35, phy_n = 0;
  // Pin is active when driven at the level the driver type demands.
  wire act = wake_request_output_oe_o === 1'b1 &&
             wake_request_output_o === (pp ? pb : 1'b0);

  always #20 clk_i = ~clk_i;

  host_fifo_level_power_regs #(.WAKE_PULSE_CYCLES(PW)) host_fifo_level_power_regs_inst (
    .clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
    .rx_status_words_used_i, .rx_data_bytes_used_i, .tx_status_words_used_i,
    .tx_data_bytes_free_i, .wol_event_i, .energy_event_i, .power_state_select_o,
    .device_ready_o, .phy_reset_request_o, .wake_interrupt_o, .wake_request_output_o,
    .wake_request_output_oe_o);

  bus_host_model host_inst (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .adr_o(adr_i),
    .dat_o(dat_i), .sel_o(sel_i), .we_o(we_i), .cyc_o(cyc_i), .stb_o(stb_i), .stuck_o(stuck));

  // ============================================================
  // Verdict and hang handling.
  task automatic give_verdict;
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge stuck)
  begin
    error_cnt++;
    give_verdict();
  end

  // Counts every cycle the PHY reset is held.
  always @(posedge clk_i)
    if (phy_reset_request_o)
      phy_n++;

  // ============================================================
  // Bus and event helpers.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_inst.xfer(1'b1, a, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host_inst.xfer(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (device_ready_o !== 1'b1 && n < LIM)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK("ready", 1'b1, device_ready_o)
    // A device that never becomes ready ends the run at once.
    if (device_ready_o !== 1'b1)
      give_verdict();
  endtask

  // One-cycle event, then the pin's active cycles are counted.
  task automatic ev(input logic w, input int k);
    int n;
    n = 0;
    @(posedge clk_i);
    wol_event_i <= w;
    energy_event_i <= ~w;
    @(posedge clk_i);
    {wol_event_i, energy_event_i} <= 2'b00;
    #1;
    `CHK("irq", 1'b1, wake_interrupt_o)
    @(posedge clk_i);
    #1;
    `CHK("irq end", 1'b0, wake_interrupt_o)
    while (act && n < LIM)
    begin
      n++;
      @(posedge clk_i);
      #1;
    end
    `CHK("pin cycles", k, n)
  endtask

  // ============================================================
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_ready();
    wr(PC, 32'h202);
    rdchk("pc first", PC, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      rdchk("rx", `ADR_RX_FIFO_INFO, {8'h00, rx_status_words_used_i, rx_data_bytes_used_i});
      rdchk("tx", `ADR_TX_FIFO_INFO, {8'h00, tx_status_words_used_i, tx_data_bytes_free_i});
      rdchk("unmapped", 8'h88, 32'h0);
      r = $random(seed);
      {rx_status_words_used_i, rx_data_bytes_used_i, tx_status_words_used_i} <= $random(seed);
      tx_data_bytes_free_i <= r[15:0]; // The bench pushes no transmit data.
      // Let the new levels land before the next expectation is formed.
      @(posedge clk_i);
    end
    {pp, pb} = 2'b11;
    wr(PC, 32'hffff_c3fd);
    rdchk("pc cfg", PC, 32'h34d);
    ev(1'b1, 0);
    ev(1'b0, 0);
    for (int p = 0; p < 2; p++)
    begin
      {pp, pb} = {1'b1, p[0]};
      wr(PC, 32'h34a | {29'h0, pb, 2'b00});
      ev(1'b1, PW);
      ev(1'b0, PW);
    end
    {pp, pb} = 2'b01;
    wr(PC, 32'h306);
    ev(1'b0, LIM);
    // Both causes are latched, so both enables must drop to free the pin.
    wr(PC, 32'h006);
    repeat (3) @(posedge clk_i);
    `CHK("pin off", 1'b0, wake_request_output_oe_o)
    phy_n = 0;
    wr(PC, 32'h400);
    wr(PC, 32'h400);
    rdchk("phy", PC, 32'h401);
    repeat (3000) @(posedge clk_i);
    `CHK("phy cycles", 2500, phy_n)
    wr(PC, 32'h3000);
    rdchk("no mode 3", PC, 32'h1);
    for (int m = 1; m < 3; m++)
    begin
      wr(PC, {18'h0, m[1:0], 12'h0});
      rdchk("sleep", PC, {18'h0, m[1:0], 12'h0});
      `CHK("mode", m[1:0], power_state_select_o)
      wr(`ADR_ENDIAN_TEST, $random(seed));
      wait_ready();
      `CHK("awake", 2'b00, power_state_select_o)
      wr(PC, 32'h2);
      rdchk("pc wake", PC, 32'h1);
    end
    give_verdict();
  end
endmodule
